/* File: shared/pll_cfg_pkg.sv */
// Package with offsets, reset values and field structs of the divider configuration bank
package pll_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Byte offsets
  localparam logic [7:0] OFF_PLL1_FB_LOW = 8'h09;
  localparam logic [7:0] OFF_PLL1_FILTER_AND_FB_HIGH = 8'h0a;
  localparam logic [7:0] OFF_PLL1_CHARGE_PUMP = 8'h0b;
  localparam logic [7:0] OFF_PLL1_SPREAD_REF_DIVIDER = 8'h0c;
  localparam logic [7:0] OFF_PLL1_SPREAD_FB_HIGH = 8'h0d;
  localparam logic [7:0] OFF_PLL1_SPREAD_FB_LOW = 8'h0e;
  localparam logic [7:0] OFF_OUTPUT_DIVIDER_ONE_TWO = 8'h0f;
  localparam logic [7:0] OFF_PLL2_INT_FB_HIGH = 8'h10;
  localparam logic [7:0] OFF_PLL2_INT_FB_LOW = 8'h11;
  localparam logic [7:0] OFF_PLL2_FRAC_FB_HIGH = 8'h12;
  localparam logic [7:0] OFF_PLL2_FRAC_FB_LOW = 8'h13;
  localparam int FIRST_OFF = 9;
  localparam int NUM_BYTES = 11;
  // Power-up values, index 0 is byte 09h
  localparam logic [7:0] RST_PLL1_FB_LOW = 8'h58;
  localparam logic [7:0] RST_PLL1_FILTER_AND_FB_HIGH = 8'hb2;
  localparam logic [7:0] RST_PLL1_CHARGE_PUMP = 8'h06;
  localparam logic [7:0] RST_PLL1_SPREAD_REF_DIVIDER = 8'h00;
  localparam logic [7:0] RST_PLL1_SPREAD_FB_HIGH = 8'h00;
  localparam logic [7:0] RST_PLL1_SPREAD_FB_LOW = 8'h00;
  localparam logic [7:0] RST_OUTPUT_DIVIDER_ONE_TWO = 8'h33;
  localparam logic [7:0] RST_PLL2_INT_FB_HIGH = 8'h00;
  localparam logic [7:0] RST_PLL2_INT_FB_LOW = 8'h3c;
  localparam logic [7:0] RST_PLL2_FRAC_FB_HIGH = 8'h00;
  localparam logic [7:0] RST_PLL2_FRAC_FB_LOW = 8'h00;
  // Writable bit masks; pll2_int_fb_high keeps only bits 2..0
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_PLL2_INT_FB_HIGH = 8'h07;
  localparam int FB_INT_W = 11;
  localparam int WIDE_W = 16;
  localparam int OUTDIV_W = 4;

  typedef struct packed {
    logic first_loop_res_large;
    logic first_loop_res_half;
    logic first_loop_res_quarter;
    logic first_loop_res_eighth;
    logic first_loop_res_only_small;
    logic [FB_INT_W-1:0] first_fb_int;
  } first_loop_t;

  typedef struct packed {
    logic first_pump_mult_32;
    logic first_pump_mult_16;
    logic first_pump_mult_8;
    logic first_pump_mult_4;
    logic first_pump_mult_2;
    logic first_pump_mult_1;
    logic first_pump_div_24;
    logic first_pump_div_3;
  } first_pump_t;

  typedef struct packed {
    logic first_spread_ref_sel23;
    logic [6:0] first_spread_ref_divider;
    logic [WIDE_W-1:0] first_spread_fb_divider;
  } first_spread_t;

  typedef struct packed {
    logic [OUTDIV_W-1:0] out_divider_one_code;
    logic [OUTDIV_W-1:0] out_divider_two_code;
  } out_div_t;

  typedef struct packed {
    logic [FB_INT_W-1:0] second_fb_int;
    logic [WIDE_W-1:0] second_fb_fraction;
  } second_fb_t;

  typedef struct packed {
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cfg_write_t;
endpackage

/* File: src/cfg_byte_reg.sv */
// One configuration byte with power-up value and writable-bit mask
`timescale 1ns/1ps
module cfg_byte_reg
  import pll_cfg_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_sel,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // Masked bits hold their reset value, so reserved bits never change
  always_comb begin
    value_next = value_reg;
    if (wr_sel) begin
      value_next = (wdata & WRITE_MASK) | (value_reg & ~WRITE_MASK);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule

/* File: src/cfg_read_mux.sv */
// Registered read-back multiplexer over the configuration bytes
`timescale 1ns/1ps
module cfg_read_mux
  import pll_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [NUM_BYTES*8-1:0] bytes_flat,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [ADDR_W-1:0] idx;

  // Unmapped offsets read as zero
  always_comb begin
    idx = rd_addr - ADDR_W'(FIRST_OFF);
    rdata_next = 8'h00;
    if (rd_addr >= ADDR_W'(FIRST_OFF) && idx < ADDR_W'(NUM_BYTES)) begin
      rdata_next = bytes_flat[idx*8 +: 8];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
endmodule

/* File: src/pll_divider_config_bank.sv */
// Byte-wide configuration bank for loop filter, pump and divider settings
`timescale 1ns/1ps
module pll_divider_config_bank
  import pll_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input cfg_write_t wr_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rdata,
  output first_loop_t first_loop,
  output first_pump_t first_pump,
  output first_spread_t first_spread,
  output out_div_t out_div,
  output second_fb_t second_fb
);
  localparam logic [7:0] RESETS [NUM_BYTES] = '{
    RST_PLL1_FB_LOW, RST_PLL1_FILTER_AND_FB_HIGH, RST_PLL1_CHARGE_PUMP,
    RST_PLL1_SPREAD_REF_DIVIDER, RST_PLL1_SPREAD_FB_HIGH, RST_PLL1_SPREAD_FB_LOW,
    RST_OUTPUT_DIVIDER_ONE_TWO, RST_PLL2_INT_FB_HIGH, RST_PLL2_INT_FB_LOW,
    RST_PLL2_FRAC_FB_HIGH, RST_PLL2_FRAC_FB_LOW};

  logic [7:0] bytes [NUM_BYTES];
  logic [NUM_BYTES*8-1:0] bytes_flat;

  // Each byte decodes its own offset; generate keeps the map in one place
  for (genvar i = 0; i < NUM_BYTES; i++) begin : g_byte
    localparam logic [7:0] OFF = 8'(FIRST_OFF + i);
    logic hit;
    assign hit = wr_req.wr_en && (wr_req.addr == OFF);
    cfg_byte_reg #(
      .RESET_VALUE(RESETS[i]),
      .WRITE_MASK((OFF == OFF_PLL2_INT_FB_HIGH) ? MASK_PLL2_INT_FB_HIGH : MASK_FULL)
    ) u_byte (
      .mclk(mclk),
      .rst(rst),
      .wr_sel(hit),
      .wdata(wr_req.wdata),
      .value(bytes[i])
    );
    assign bytes_flat[i*8 +: 8] = bytes[i];
  end

  cfg_read_mux u_rd (
    .mclk(mclk),
    .rst(rst),
    .rd_addr(rd_addr),
    .bytes_flat(bytes_flat),
    .rdata(rdata)
  );

  // Field decode, registered again so outputs come from flip-flops
  first_loop_t first_loop_reg;
  first_loop_t first_loop_next;
  first_pump_t first_pump_reg;
  first_pump_t first_pump_next;
  first_spread_t first_spread_reg;
  first_spread_t first_spread_next;
  out_div_t out_div_reg;
  out_div_t out_div_next;
  second_fb_t second_fb_reg;
  second_fb_t second_fb_next;

  always_comb begin
    first_loop_next.first_loop_res_large = bytes[1][7];
    first_loop_next.first_loop_res_half = bytes[1][6];
    first_loop_next.first_loop_res_quarter = bytes[1][5];
    first_loop_next.first_loop_res_eighth = bytes[1][4];
    first_loop_next.first_loop_res_only_small = bytes[1][3];
    first_loop_next.first_fb_int = {bytes[1][2:0], bytes[0]};
    first_pump_next = bytes[2];
    first_spread_next.first_spread_ref_sel23 = bytes[3][7];
    first_spread_next.first_spread_ref_divider = bytes[3][6:0];
    first_spread_next.first_spread_fb_divider = {bytes[4], bytes[5]};
    out_div_next.out_divider_one_code = bytes[6][7:4];
    out_div_next.out_divider_two_code = bytes[6][3:0];
    second_fb_next.second_fb_int = {bytes[7][2:0], bytes[8]};
    second_fb_next.second_fb_fraction = {bytes[9], bytes[10]};
  end

  // Reset images match the byte reset values so outputs agree from the start
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_loop_reg <= {RST_PLL1_FILTER_AND_FB_HIGH[7:3], RST_PLL1_FILTER_AND_FB_HIGH[2:0], RST_PLL1_FB_LOW};
      first_pump_reg <= RST_PLL1_CHARGE_PUMP;
      first_spread_reg <= {RST_PLL1_SPREAD_REF_DIVIDER, RST_PLL1_SPREAD_FB_HIGH, RST_PLL1_SPREAD_FB_LOW};
      out_div_reg <= RST_OUTPUT_DIVIDER_ONE_TWO;
      second_fb_reg <= {RST_PLL2_INT_FB_HIGH[2:0], RST_PLL2_INT_FB_LOW, RST_PLL2_FRAC_FB_HIGH,
                        RST_PLL2_FRAC_FB_LOW};
    end else begin
      first_loop_reg <= first_loop_next;
      first_pump_reg <= first_pump_next;
      first_spread_reg <= first_spread_next;
      out_div_reg <= out_div_next;
      second_fb_reg <= second_fb_next;
    end
  end

  assign first_loop = first_loop_reg;
  assign first_pump = first_pump_reg;
  assign first_spread = first_spread_reg;
  assign out_div = out_div_reg;
  assign second_fb = second_fb_reg;

  // Assertions
  a_reserved_read_zero: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL2_INT_FB_HIGH |=> rdata[7:3] == 5'h00)
    else $error("reserved bits of second divider high read nonzero");
  a_reserved_hold: assert property (@(posedge mclk) disable iff (rst)
    bytes[7][7:3] == 5'h00)
    else $error("reserved bits of second divider high changed");
  a_loop_res_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_loop_res_large == $past(wr_req.wdata[7], 2))
    else $error("large loop resistor not taken from write");
  a_small_res_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_loop_res_only_small == $past(wr_req.wdata[3], 2))
    else $error("small loop resistor not taken from write");
  a_first_fb_high: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_fb_int[10:8] == $past(wr_req.wdata[2:0], 2))
    else $error("first divider high bits wrong");
  a_first_fb_low: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FB_LOW
    |=> ##1 first_loop.first_fb_int[7:0] == $past(wr_req.wdata, 2))
    else $error("first divider low bits wrong");
  a_pump_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_CHARGE_PUMP |=> ##1 first_pump == $past(wr_req.wdata, 2))
    else $error("pump byte not taken");
  a_spread_ref: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_SPREAD_REF_DIVIDER
    |=> ##1 first_spread.first_spread_ref_sel23 == $past(wr_req.wdata[7], 2))
    else $error("spread ref select not taken");
  a_spread_fb_high: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_SPREAD_FB_HIGH
    |=> ##1 first_spread.first_spread_fb_divider[15:8] == $past(wr_req.wdata, 2))
    else $error("spread feedback high wrong");
  a_out_div_two: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_OUTPUT_DIVIDER_ONE_TWO
    |=> ##1 out_div.out_divider_two_code == $past(wr_req.wdata[3:0], 2))
    else $error("output divider two wrong");
  a_out_div_reset: assert property (@(posedge mclk)
    $fell(rst) |-> out_div == RST_OUTPUT_DIVIDER_ONE_TWO)
    else $error("output divider reset value wrong");
  a_second_int_high: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL2_INT_FB_HIGH
    |=> ##1 second_fb.second_fb_int[10:8] == $past(wr_req.wdata[2:0], 2))
    else $error("second divider high wrong");
  a_second_int_reset: assert property (@(posedge mclk)
    $fell(rst) |-> second_fb.second_fb_int == {RST_PLL2_INT_FB_HIGH[2:0], RST_PLL2_INT_FB_LOW})
    else $error("second divider reset value wrong");
  a_second_frac_low: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL2_FRAC_FB_LOW
    |=> ##1 second_fb.second_fb_fraction[7:0] == $past(wr_req.wdata, 2))
    else $error("second fraction low wrong");
  c_write_loop: cover property (@(posedge mclk) wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH);
  c_write_reserved: cover property (@(posedge mclk) wr_req.wr_en && wr_req.addr == OFF_PLL2_INT_FB_HIGH
    && wr_req.wdata[7:3] != 5'h00);
  c_read_fraction: cover property (@(posedge mclk) rd_addr == OFF_PLL2_FRAC_FB_HIGH);
  c_back_to_back: cover property (@(posedge mclk) wr_req.wr_en ##1 wr_req.wr_en);
  c_reset_release: cover property (@(posedge mclk) $fell(rst));

  // Remaining fields, two edges after the taking edge
  a_half_res_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_loop_res_half == $past(wr_req.wdata[6], 2))
    else $error("half loop resistor not taken from write");
  a_quarter_res_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_loop_res_quarter == $past(wr_req.wdata[5], 2))
    else $error("quarter loop resistor not taken from write");
  a_eighth_res_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_FILTER_AND_FB_HIGH
    |=> ##1 first_loop.first_loop_res_eighth == $past(wr_req.wdata[4], 2))
    else $error("eighth loop resistor not taken from write");
  a_spread_ref_div: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_SPREAD_REF_DIVIDER
    |=> ##1 first_spread.first_spread_ref_divider == $past(wr_req.wdata[6:0], 2))
    else $error("spread ref divider not taken");
  a_spread_fb_low: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL1_SPREAD_FB_LOW
    |=> ##1 first_spread.first_spread_fb_divider[7:0] == $past(wr_req.wdata, 2))
    else $error("spread feedback low wrong");
  a_out_div_one: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_OUTPUT_DIVIDER_ONE_TWO
    |=> ##1 out_div.out_divider_one_code == $past(wr_req.wdata[7:4], 2))
    else $error("output divider one wrong");
  a_second_int_low: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL2_INT_FB_LOW
    |=> ##1 second_fb.second_fb_int[7:0] == $past(wr_req.wdata, 2))
    else $error("second divider low wrong");
  a_second_frac_high: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL2_FRAC_FB_HIGH
    |=> ##1 second_fb.second_fb_fraction[15:8] == $past(wr_req.wdata, 2))
    else $error("second fraction high wrong");

  // Reserved bits dropped, offsets outside the map ignored
  a_reserved_write_drop: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && wr_req.addr == OFF_PLL2_INT_FB_HIGH
    |=> bytes[7] == {5'h00, $past(wr_req.wdata[2:0])})
    else $error("second divider high byte took reserved bits");
  a_refused_write: assert property (@(posedge mclk) disable iff (rst)
    wr_req.wr_en && (wr_req.addr < OFF_PLL1_FB_LOW || wr_req.addr > OFF_PLL2_FRAC_FB_LOW)
    |=> $stable(bytes_flat))
    else $error("write outside the map changed a byte");
  a_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
    rd_addr < OFF_PLL1_FB_LOW || rd_addr > OFF_PLL2_FRAC_FB_LOW |=> rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  // A field may only move two edges after a write
  a_loop_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en |=> ##1 $stable(first_loop))
    else $error("loop fields changed without a write");
  a_pump_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en |=> ##1 $stable(first_pump))
    else $error("pump fields changed without a write");
  a_spread_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en |=> ##1 $stable(first_spread))
    else $error("spread fields changed without a write");
  a_out_div_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en |=> ##1 $stable(out_div))
    else $error("output divider codes changed without a write");
  a_second_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en |=> ##1 $stable(second_fb))
    else $error("second divider fields changed without a write");
  a_read_stands: assert property (@(posedge mclk) disable iff (rst)
    !wr_req.wr_en ##1 $stable(rd_addr) |=> $stable(rdata))
    else $error("read data changed with a steady address");

  // Power-up images at the first edge after reset
  a_loop_res_reset: assert property (@(posedge mclk)
    $fell(rst) |-> first_loop[15:11] == RST_PLL1_FILTER_AND_FB_HIGH[7:3])
    else $error("loop resistor reset value wrong");
  a_first_fb_reset: assert property (@(posedge mclk)
    $fell(rst) |-> first_loop.first_fb_int == {RST_PLL1_FILTER_AND_FB_HIGH[2:0], RST_PLL1_FB_LOW})
    else $error("first divider reset value wrong");
  a_pump_reset: assert property (@(posedge mclk)
    $fell(rst) |-> first_pump == RST_PLL1_CHARGE_PUMP)
    else $error("pump reset value wrong");
  a_spread_reset: assert property (@(posedge mclk)
    $fell(rst) |-> first_spread == {RST_PLL1_SPREAD_REF_DIVIDER, RST_PLL1_SPREAD_FB_HIGH, RST_PLL1_SPREAD_FB_LOW})
    else $error("spread reset value wrong");
  a_second_high_reset: assert property (@(posedge mclk)
    $fell(rst) |-> second_fb.second_fb_int[10:8] == RST_PLL2_INT_FB_HIGH[2:0])
    else $error("second divider high reset value wrong");
  a_second_frac_reset: assert property (@(posedge mclk)
    $fell(rst) |-> second_fb.second_fb_fraction == {RST_PLL2_FRAC_FB_HIGH, RST_PLL2_FRAC_FB_LOW})
    else $error("second fraction reset value wrong");
  a_read_reset: assert property (@(posedge mclk)
    $fell(rst) |-> rdata == 8'h00)
    else $error("read data not cleared by reset");

  // Read path and field decode are separate logic; both see one byte image
  a_read_first_low: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_FB_LOW |=> rdata == first_loop[7:0])
    else $error("first divider low read back differs");
  a_read_loop_byte: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_FILTER_AND_FB_HIGH |=> rdata == first_loop[15:8])
    else $error("loop byte read back differs");
  a_read_pump: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_CHARGE_PUMP |=> rdata == first_pump)
    else $error("pump byte read back differs");
  a_read_ref_div: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_SPREAD_REF_DIVIDER
    |=> rdata == {first_spread.first_spread_ref_sel23, first_spread.first_spread_ref_divider})
    else $error("spread ref byte read back differs");
  a_read_spread_high: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_SPREAD_FB_HIGH |=> rdata == first_spread.first_spread_fb_divider[15:8])
    else $error("spread feedback high read back differs");
  a_read_spread_low: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL1_SPREAD_FB_LOW |=> rdata == first_spread.first_spread_fb_divider[7:0])
    else $error("spread feedback low read back differs");
  a_read_out_div: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_OUTPUT_DIVIDER_ONE_TWO |=> rdata == out_div)
    else $error("output divider byte read back differs");
  a_read_second_high: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL2_INT_FB_HIGH |=> rdata == {5'h00, second_fb.second_fb_int[10:8]})
    else $error("second divider high read back differs");
  a_read_second_low: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL2_INT_FB_LOW |=> rdata == second_fb.second_fb_int[7:0])
    else $error("second divider low read back differs");
  a_read_fraction_high: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL2_FRAC_FB_HIGH |=> rdata == second_fb.second_fb_fraction[15:8])
    else $error("second fraction high read back differs");
  a_read_fraction_low: assert property (@(posedge mclk) disable iff (rst)
    rd_addr == OFF_PLL2_FRAC_FB_LOW |=> rdata == second_fb.second_fb_fraction[7:0])
    else $error("second fraction low read back differs");
endmodule

/* File: tb/cfg_host_model.sv */
// Host model driving the parallel configuration byte port
`timescale 1ns/1ps
module cfg_host_model
  import pll_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic [DATA_W-1:0] rdata,
  output cfg_write_t wr_req,
  output logic [ADDR_W-1:0] rd_addr
);
  initial begin
    wr_req = '0;
    rd_addr = 8'h00;
  end

  // Caller sits just after an edge; request holds through the taking edge
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    wr_req = '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge mclk);
    #1;
  endtask

  // Released lines flip so a stale value is never mistaken for live data
  task automatic wr_stop();
    wr_req = '{wr_en: 1'b0, addr: ~wr_req.addr, wdata: ~wr_req.wdata};
    @(posedge mclk);
    #1;
  endtask

  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    rd_addr = a;
    @(posedge mclk);
    #1;
    d = rdata;
  endtask
endmodule

/* File: tb/pll_divider_config_bank_tb_top.sv */
// Self-checking bench for the divider configuration bank
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module pll_divider_config_bank_tb_top;
  import pll_cfg_pkg::*;
  logic mclk;
  logic rst;
  cfg_write_t wr_req;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rdata;
  first_loop_t first_loop;
  first_pump_t first_pump;
  first_spread_t first_spread;
  out_div_t out_div;
  second_fb_t second_fb;
  int num_errors = 0;
  int tests_run = 0;
  logic [7:0] pwd [11] = '{8'h58, 8'hb2, 8'h06, 8'h00, 8'h00, 8'h00, 8'h33, 8'h00, 8'h3c, 8'h00, 8'h00};
  logic [7:0] pat [11] = '{8'hc3, 8'ha5, 8'h5a, 8'h96, 8'he1, 8'h7b, 8'hd4, 8'h6d, 8'hb9, 8'h2e, 8'hf0};

  pll_divider_config_bank i_pll_divider_config_bank (
    .mclk(mclk), .rst(rst), .wr_req(wr_req), .rd_addr(rd_addr), .rdata(rdata),
    .first_loop(first_loop), .first_pump(first_pump), .first_spread(first_spread),
    .out_div(out_div), .second_fb(second_fb)
  );
  cfg_host_model i_cfg_host_model (.mclk(mclk), .rdata(rdata), .wr_req(wr_req), .rd_addr(rd_addr));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Reads every byte 09h..13h, then every field output
  task automatic check_all(input bit written);
    logic [7:0] e [11];
    logic [7:0] d;
    for (int i = 0; i < 11; i++) begin
      e[i] = written ? pat[i] : pwd[i];
    end
    e[7] = e[7] & 8'h07;
    for (int i = 0; i < 11; i++) begin
      i_cfg_host_model.rd_byte(8'h09 + 8'(i), d);
      `CHK(d, e[i])
    end
    `CHK(first_loop, {e[1], e[0]})
    `CHK(first_pump, e[2])
    `CHK(first_spread, {e[3], e[4], e[5]})
    `CHK(out_div, e[6])
    `CHK(second_fb, {e[7][2:0], e[8], e[9], e[10]})
  endtask

  task automatic test_power_up();
    check_all(1'b0);
    `CHK(first_loop.first_fb_int, 11'd600)
    `CHK(out_div.out_divider_two_code, 4'b0011)
  endtask

  // Back-to-back writes, then refused writes just outside the map
  task automatic test_write_all();
    logic [7:0] d;
    for (int i = 0; i < 11; i++) begin
      i_cfg_host_model.wr_byte(8'h09 + 8'(i), pat[i]);
    end
    i_cfg_host_model.wr_byte(8'h08, 8'hff);
    i_cfg_host_model.wr_byte(8'h14, 8'hff);
    i_cfg_host_model.wr_stop();
    i_cfg_host_model.rd_byte(8'h14, d);
    `CHK(d, 8'h00)
    check_all(1'b1);
  endtask

  task automatic test_reserved();
    logic [7:0] d;
    i_cfg_host_model.wr_byte(8'h10, 8'hf8);
    i_cfg_host_model.wr_stop();
    i_cfg_host_model.rd_byte(8'h10, d);
    `CHK(d, 8'h00)
    i_cfg_host_model.wr_byte(8'h10, 8'hff);
    i_cfg_host_model.wr_stop();
    i_cfg_host_model.rd_byte(8'h10, d);
    `CHK(d, 8'h07)
    `CHK(second_fb.second_fb_int, {3'h7, pat[8]})
  endtask

  // One resistor bit at a time, so a swapped pair shows up
  task automatic test_filter_bits();
    for (int b = 3; b < 8; b++) begin
      i_cfg_host_model.wr_byte(8'h0a, 8'h01 << b);
      i_cfg_host_model.wr_stop();
      `CHK(first_loop[15:11], 5'h01 << (b - 3))
      `CHK(first_loop.first_fb_int, {3'h0, pat[0]})
    end
  endtask

  task automatic test_reset_again();
    rst = 1'b1;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    check_all(1'b0);
  endtask

  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    test_power_up();
    test_write_all();
    test_reserved();
    test_filter_bits();
    test_reset_again();
    tally_and_finish();
  end

  // Whole run is about 85 cycles; allow 3000, over thirty times that
  initial begin
    #(3000 * 8);
    num_errors++;
    tally_and_finish();
  end
endmodule
